// *** design/patch_pkg.sv ***
package patch_pkg;

   // ======================================================
   // Register map
   localparam logic [15:0] PATCH_ADDR0_OFS = 16'hFF38;
   localparam logic [15:0] PATCH_ADDR1_OFS = 16'hFF3A;
   // Control register offset is free; kept next to the address pair
   localparam logic [15:0] PATCH_CTRL_OFS = 16'hFF3C;

   localparam logic [15:0] PATCH_ADDR_RST = 16'h0000;
   localparam logic [7:0] PATCH_CTRL_RST = 8'h00;

   // ======================================================
   // Control register fields
   localparam int SLOT0_FLAG_BIT = 0;
   localparam int SLOT0_EN_BIT = 1;
   localparam int SLOT1_FLAG_BIT = 2;
   localparam int SLOT1_EN_BIT = 3;
   localparam logic [7:0] CTRL_FLAG_MASK = 8'h05;

   // Redirect target in expansion RAM
   localparam logic [15:0] REDIRECT_VECTOR = 16'hF7FD;
   localparam int NUM_SLOTS = 2;

   // ======================================================
   // Register write request
   typedef enum logic [1:0]
   {
      WR_NONE,
      WR_BYTE,
      WR_WORD,
      WR_BIT
   } wr_kind_t;

   typedef struct packed
   {
      wr_kind_t kind;
      logic [15:0] addr;
      logic [15:0] data;
      logic [2:0] bit_sel;
      logic bit_val;
   } reg_wr_t;

   typedef struct packed
   {
      logic valid;
      logic [15:0] addr;
   } fetch_t;

endpackage

// *** design/patch_slot.sv ***
`timescale 1ns/1ps
`default_nettype none

module patch_slot
   import patch_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic addr_we_i,
   input wire logic [15:0] addr_wdata_i,
   input wire logic enable_i,
   input wire fetch_t fetch_i,
   output logic [15:0] addr_o,
   output logic hit_o
);

   logic [15:0] patch_addr_r;

   // ======================================================
   // Address register
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         patch_addr_r <= PATCH_ADDR_RST;
      else if (addr_we_i)
         patch_addr_r <= addr_wdata_i;
   end

   assign addr_o = patch_addr_r;
   // Enable gates only the comparison; address may still be rewritten
   assign hit_o = fetch_i.valid && enable_i &&
                  (fetch_i.addr == patch_addr_r);

endmodule

`default_nettype wire

// *** design/patch_redirect.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Two 16-bit patch addresses, cleared at reset
// - Enabled match on fetch requests branch to F7FDH
// - Matching slot flag set with the branch
// - Slot enables at control bits 1 and 3
// - Control resets 00H, bit and byte writes
// - Flag bits 0 and 2 set by hardware, software writes can only clear them
// - Address registers take 16-bit writes at FF38H/FF3AH
// - Bit-test-and-clear branch clears the flag
module patch_redirect
   import patch_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire fetch_t FETCH_I,
   input wire reg_wr_t REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [15:0] REG_RD_ADDR_I,
   output logic [15:0] REG_RD_DATA_O,
   output logic BRANCH_REQ_O,
   output logic [15:0] BRANCH_TARGET_O,
   output logic SQUASH_O
);

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [NUM_SLOTS-1:0] hit;
   logic [NUM_SLOTS-1:0] addr_we;
   logic [15:0] slot_addr [NUM_SLOTS];
   logic ctrl_wr;
   logic [15:0] rd_data_nxt;

   // ======================================================
   // Slots
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++)
      begin : g_slot
         localparam logic [15:0] OFS = (g == 0) ?
            PATCH_ADDR0_OFS : PATCH_ADDR1_OFS;
         assign addr_we[g] = (REG_WR_I.kind == WR_WORD) &&
                             (REG_WR_I.addr == OFS);
         patch_slot u_slot
         (
            .clk_i(CLK_SYS_I),
            .srst_i(SRST_I),
            .addr_we_i(addr_we[g]),
            .addr_wdata_i(REG_WR_I.data),
            .enable_i(ctrl_r[2*g+1]),
            .fetch_i(FETCH_I),
            .addr_o(slot_addr[g]),
            .hit_o(hit[g])
         );
      end
   endgenerate

   // ======================================================
   // Control register
   assign ctrl_wr = (REG_WR_I.addr == PATCH_CTRL_OFS) &&
                    ((REG_WR_I.kind == WR_BYTE) ||
                     (REG_WR_I.kind == WR_BIT));

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr)
      begin
         if (REG_WR_I.kind == WR_BYTE)
         begin
            // Flags may only be cleared by software, never set
            ctrl_nxt = (REG_WR_I.data[7:0] & ~CTRL_FLAG_MASK) |
                       (REG_WR_I.data[7:0] & ctrl_r &
                        CTRL_FLAG_MASK);
         end
         else if (CTRL_FLAG_MASK[REG_WR_I.bit_sel] == 1'b0 ||
                  REG_WR_I.bit_val == 1'b0)
         begin
            ctrl_nxt[REG_WR_I.bit_sel] = REG_WR_I.bit_val;
         end
      end
      // Hardware set wins over a simultaneous clear
      if (hit[0])
         ctrl_nxt[SLOT0_FLAG_BIT] = 1'b1;
      if (hit[1])
         ctrl_nxt[SLOT1_FLAG_BIT] = 1'b1;
      ctrl_nxt[7:4] = 4'h0;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         ctrl_r <= PATCH_CTRL_RST;
      else
         ctrl_r <= ctrl_nxt;
   end

   // ======================================================
   // Redirect to fetch unit; same-cycle so the hit opcode is dropped
   assign BRANCH_REQ_O = |hit;
   assign SQUASH_O = |hit;
   assign BRANCH_TARGET_O = REDIRECT_VECTOR;

   // ======================================================
   // Read port
   always_comb
   begin
      rd_data_nxt = 16'h0000;
      if (REG_RD_ADDR_I == PATCH_ADDR0_OFS)
         rd_data_nxt = slot_addr[0];
      else if (REG_RD_ADDR_I == PATCH_ADDR1_OFS)
         rd_data_nxt = slot_addr[1];
      else if (REG_RD_ADDR_I == PATCH_CTRL_OFS)
         rd_data_nxt = {8'h00, ctrl_r};
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         REG_RD_DATA_O <= 16'h0000;
      else if (REG_RD_I)
         REG_RD_DATA_O <= rd_data_nxt;
   end

   // ======================================================
   // Checks
   branch_hit_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      BRANCH_REQ_O == ((FETCH_I.valid && ctrl_r[SLOT0_EN_BIT] &&
      FETCH_I.addr == slot_addr[0]) || (FETCH_I.valid &&
      ctrl_r[SLOT1_EN_BIT] && FETCH_I.addr == slot_addr[1])))
      else $error("Branch request disagrees with match");
   idle_quiet_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      !FETCH_I.valid |-> !BRANCH_REQ_O && !SQUASH_O)
      else $error("Branch request without a fetch");
   flag0_set_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      hit[0] |=> ctrl_r[SLOT0_FLAG_BIT])
      else $error("Slot 0 flag not set on match");
   flag1_set_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      hit[1] |=> ctrl_r[SLOT1_FLAG_BIT])
      else $error("Slot 1 flag not set on match");
   flag_ro_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (!ctrl_r[SLOT0_FLAG_BIT] && !hit[0]) |=> !ctrl_r[SLOT0_FLAG_BIT])
      else $error("Slot 0 flag set without match");
   flag1_ro_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (!ctrl_r[SLOT1_FLAG_BIT] && !hit[1]) |=> !ctrl_r[SLOT1_FLAG_BIT])
      else $error("Slot 1 flag set without match");
   target_vec_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      BRANCH_REQ_O |-> BRANCH_TARGET_O == 16'hF7FD && SQUASH_O)
      else $error("Redirect target or squash wrong");
   ctrl_rst_a: assert property (
      @(posedge CLK_SYS_I)
      SRST_I |=> ctrl_r == 8'h00 && slot_addr[0] == 16'h0000 &&
      slot_addr[1] == 16'h0000)
      else $error("Registers not cleared by reset");
   addr_wr_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      addr_we[1] |=> slot_addr[1] == $past(REG_WR_I.data))
      else $error("Slot 1 address not loaded");
   addr0_wr_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      addr_we[0] |=> slot_addr[0] == $past(REG_WR_I.data))
      else $error("Slot 0 address not loaded");
   en_byte_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (ctrl_wr && REG_WR_I.kind == WR_BYTE) |=>
      ctrl_r[SLOT1_EN_BIT] == $past(REG_WR_I.data[3]))
      else $error("Slot 1 enable not written");
   en0_byte_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (ctrl_wr && REG_WR_I.kind == WR_BYTE) |=>
      ctrl_r[SLOT0_EN_BIT] == $past(REG_WR_I.data[1]))
      else $error("Slot 0 enable not written");
   clr_wr_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (ctrl_wr && REG_WR_I.kind == WR_BIT && REG_WR_I.bit_sel == 3'd0 &&
      !REG_WR_I.bit_val && !hit[0]) |=> !ctrl_r[SLOT0_FLAG_BIT])
      else $error("Slot 0 flag clear lost");
   clr1_wr_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (ctrl_wr && REG_WR_I.kind == WR_BIT && REG_WR_I.bit_sel == 3'd2 &&
      !REG_WR_I.bit_val && !hit[1]) |=> !ctrl_r[SLOT1_FLAG_BIT])
      else $error("Slot 1 flag clear lost");
   upper_zero_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      ctrl_r[7:4] == 4'h0)
      else $error("Unused control bits not zero");
   ctrl_word_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (REG_WR_I.kind == WR_WORD && REG_WR_I.addr == PATCH_CTRL_OFS &&
      !(|hit)) |=> ctrl_r == $past(ctrl_r))
      else $error("Word write changed control register");
   rd_ctrl_a: assert property (
      @(posedge CLK_SYS_I) disable iff (SRST_I)
      (REG_RD_I && REG_RD_ADDR_I == PATCH_CTRL_OFS) |=>
      REG_RD_DATA_O == {8'h00, $past(ctrl_r)})
      else $error("Control read data wrong");

   redir0_c: cover property (@(posedge CLK_SYS_I) hit[0]);
   redir1_c: cover property (@(posedge CLK_SYS_I) hit[1]);
   clr_c: cover property (@(posedge CLK_SYS_I)
      ctrl_r[SLOT0_FLAG_BIT] ##1 !ctrl_r[SLOT0_FLAG_BIT]);
   // Match and software clear together: the set must win
   set_wins_c: cover property (@(posedge CLK_SYS_I)
      hit[0] && ctrl_wr && REG_WR_I.kind == WR_BIT &&
      REG_WR_I.bit_sel == 3'd0 && !REG_WR_I.bit_val);
   both_en_c: cover property (@(posedge CLK_SYS_I)
      ctrl_r[SLOT0_EN_BIT] && ctrl_r[SLOT1_EN_BIT]);

endmodule

`default_nettype wire

// *** verif/fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ======================================================
// Fetch unit: fetches one opcode a cycle, jumps on squash
module fetch_model
   import patch_pkg::*;
(
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [15:0] start_i,
   input wire logic squash_i,
   input wire logic [15:0] target_i,
   output var fetch_t fetch_o
);
   // Routine reached through the branch held at the vector; arbitrary
   localparam logic [15:0] ROUTINE_ADDR = 16'hF700;
   logic [15:0] pc_r;

   // Loading while idle keeps the stream contiguous once run rises
   always_ff @(posedge clk_i)
   begin
      if (!run_i)
         pc_r <= start_i;
      else if (squash_i)
         pc_r <= target_i;
      else if (pc_r == target_i)
         pc_r <= ROUTINE_ADDR;
      else
         // Every fetch starts an opcode; no flow-ending opcodes here
         pc_r <= pc_r + 16'h0001;
   end

   always_comb
   begin
      fetch_o.valid = run_i;
      fetch_o.addr = pc_r;
   end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench
   import patch_pkg::*;
   ;
   logic clk, srst, rd, run, br, sq;
   logic [15:0] rd_addr, rd_data, tgt, start, d0, d1;
   reg_wr_t wr;
   fetch_t fe;
   int failures, n_checks, seed, a0, a1, ctrl;
   int cyc = 0;

   patch_redirect DUT (.CLK_SYS_I(clk), .SRST_I(srst), .FETCH_I(fe),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RD_ADDR_I(rd_addr),
      .REG_RD_DATA_O(rd_data), .BRANCH_REQ_O(br),
      .BRANCH_TARGET_O(tgt), .SQUASH_O(sq));
   fetch_model CPU (.clk_i(clk), .run_i(run), .start_i(start),
      .squash_i(sq), .target_i(tgt), .fetch_o(fe));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ======================================================
   // Tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic put(wr_kind_t k, logic [15:0] a, logic [15:0] d,
      logic [2:0] b, logic v);
      wr = '{kind: k, addr: a, data: d, bit_sel: b, bit_val: v};
      if (k == WR_WORD && a == PATCH_ADDR0_OFS) a0 = d;
      if (k == WR_WORD && a == PATCH_ADDR1_OFS) a1 = d;
      // Flags can only be cleared by software
      if (k == WR_BYTE && a == PATCH_CTRL_OFS)
         ctrl = (d & 16'h000a) | (ctrl & d & 16'h0005);
      if (k == WR_BIT && a == PATCH_CTRL_OFS)
         ctrl = v ? ctrl | ((b == 1 || b == 3) << b) : ctrl & ~(1 << b);
      @(posedge clk);
      wr.kind <= WR_NONE;
      @(negedge clk);
   endtask

   task automatic rd_chk(logic [15:0] a, int e);
      rd = 1'b1;
      rd_addr = a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      n_checks++;
      if (rd_data !== e[15:0])
      begin
         failures++;
         $display("MISMATCH reg %h exp %h got %h", a, e[15:0], rd_data);
      end
   endtask

   task automatic cmp_br(logic e);
      n_checks++;
      if (br !== e || sq !== e || (e && tgt !== REDIRECT_VECTOR))
      begin
         failures++;
         $display("MISMATCH branch exp %b got %b", e, br);
      end
   endtask

   task automatic fetch_run(logic [15:0] s, int n);
      int h;
      start = s;
      @(negedge clk);
      run = 1'b1;
      repeat (n)
      begin
         h = (fe.addr == a0 && ctrl[1]) + 2 * (fe.addr == a1 && ctrl[3]);
         cmp_br(h != 0);
         ctrl = ctrl | (h[0] ? 1 : 0) | (h[1] ? 4 : 0);
         @(negedge clk);
      end
      run = 1'b0;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         stop_test();
      end
   end

   // ======================================================
   // Main sequence
   initial
   begin
      seed = 32'hef56;
      {failures, n_checks, a0, a1, ctrl} = '0;
      {srst, rd, rd_addr, run, start, wr} = '0;
      srst = 1'b1;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      rd_chk(PATCH_ADDR0_OFS, a0);
      rd_chk(PATCH_ADDR1_OFS, a1);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      $display("reset values done");
      // Kept clear of the vector and table-call areas
      d0 = 16'(16'h0080 + ($random(seed) & 16'h3fff));
      d1 = 16'(16'h4080 + ($random(seed) & 16'h3fff));
      put(WR_WORD, PATCH_ADDR0_OFS, d0, 3'h0, 1'b0);
      put(WR_WORD, PATCH_ADDR1_OFS, d1, 3'h0, 1'b0);
      put(WR_BYTE, PATCH_ADDR0_OFS, 16'h00ff, 3'h0, 1'b0);
      put(WR_BIT, PATCH_ADDR1_OFS, 16'h0000, 3'h0, 1'b1);
      rd_chk(PATCH_ADDR0_OFS, a0);
      rd_chk(PATCH_ADDR1_OFS, a1);
      rd_chk(16'h0010, 0);
      $display("address registers done");
      put(WR_BIT, PATCH_CTRL_OFS, 16'h0000, 3'h1, 1'b1);
      fetch_run(d0 - 16'h0002, 6);
      fetch_run(d1 - 16'h0001, 3);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      put(WR_BYTE, PATCH_CTRL_OFS, 16'h00ff, 3'h0, 1'b0);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      fetch_run(d1 - 16'h0001, 4);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      put(WR_BIT, PATCH_CTRL_OFS, 16'h0000, 3'h0, 1'b0);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      put(WR_BYTE, PATCH_CTRL_OFS, 16'h0000, 3'h0, 1'b0);
      rd_chk(PATCH_CTRL_OFS, ctrl);
      fetch_run(d0 - 16'h0001, 3);
      $display("redirect and flags done");
      stop_test();
   end
endmodule
`default_nettype wire
